/* File: inc/i2crf_pkg.sv */
package i2crf_pkg;

    // ****************************************
    // Bus address and register file layout
    // ****************************************
    localparam logic [6:0] DEV_ADDR      = 7'h5c;
    localparam logic [3:0] NVM_ADDR_HI   = 4'ha;
    localparam int         NUM_REGS      = 16;
    localparam int         PTR_W         = 4;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    localparam logic [3:0] BIT_CNT_LAST  = 4'h7;
    localparam logic [3:0] BIT_CNT_ACK   = 4'h8;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        I2CRF_IDLE  = 3'b000,
        I2CRF_DADDR = 3'b001,
        I2CRF_RADDR = 3'b010,
        I2CRF_WDATA = 3'b011,
        I2CRF_RDATA = 3'b100,
        I2CRF_SKIP  = 3'b101
    } i2crf_state_t;

    typedef struct packed {
        logic scl_in;
        logic sda_in;
        logic sda_out;
        logic sda_oe_n;
    } i2crf_pins_t;

    typedef struct packed {
        logic [1:0]   scl_sync;
        logic [1:0]   sda_sync;
        logic         scl_d;
        logic         sda_d;
        logic [1:0]   mode_sync;
        logic         prog_d;
        i2crf_state_t state;
        logic [3:0]   bit_cnt;
        logic [7:0]   shift;
        logic [PTR_W-1:0] ptr;
        logic         ack_phase;
        logic         drive_low;
        logic         rd_nack;
        logic         wr_pulse;
        logic [PTR_W-1:0] wr_addr;
        logic [7:0]   wr_data;
    } i2crf_ctl_t;

endpackage : i2crf_pkg

/* File: logic/i2crf_slave.sv */
`timescale 1ns/1ps
// Behaviour
// [R1] Acts only as read/write slave; general-call address is not acknowledged.
// [R2] Master drives clock and makes START/STOP; device never drives clock.
// [R3] Transfers begin only from idle bus, both lines high.
// [R4] START is data falling while clock high; begins every command.
// [R5] STOP is data rising while clock high; ends every command.
// [R6] Data changes only while clock low; sampled on clock rising edge.
// [R7] Receiver pulls data low through ninth clock pulse to acknowledge.
// [R8] Master withholds acknowledge on last read; slave releases data line.
// [R9] Match seven-bit address 1011100 plus direction; acknowledge only on match.
// [R10] Leave nonvolatile store addresses 1010xxx alone.
// [R11] Write: first byte loads pointer, next acknowledged byte writes register.
// [R12] STOP or repeated START mid-byte discards partial write data.
// [R13] Sequential writes increment pointer, wrapping after sixteen bytes.
// [R14] Register takes its value when the device acknowledges the byte.
// [R15] Random read keeps pointer set earlier, acknowledges, transmits one byte.
// [R16] Pointer increments by one after each transmitted byte.
// [R17] Sequential read returns bytes from addressed register, wrapping past last.
// [R18] Port runs only while mode input is low (program mode).
// [R19] Entering program mode clears all sixteen registers to zero.
// [R20] Pointer is four bits; upper bits of register address ignored.
// [R21] Data line released whenever not acknowledging or transmitting.
module i2crf_slave #(
    parameter int NREGS = i2crf_pkg::NUM_REGS
) (
    input  wire logic                 i_clk_sys,
    input  wire logic                 i_reset_n,
    input  wire logic                 i_mode,
    input  wire logic                 i_powerdown_or_serial_clock_pin,
    input  wire logic                 i_sda,
    output logic                      o_sda,
    output logic                      o_sda_oe_n,
    output logic [NREGS*8-1:0]        o_regs,
    output logic                      o_reg_wr,
    output logic [i2crf_pkg::PTR_W-1:0] o_reg_wr_addr
);
    import i2crf_pkg::*;

    // ****************************************
    // State
    // ****************************************
    i2crf_ctl_t c_r;
    i2crf_ctl_t c_nxt;
    logic [7:0] regs_r [NREGS];

    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic prog;
    logic prog_enter;
    logic [7:0] shifted;
    logic [7:0] rd_byte;

    always_comb begin
        scl_s      = c_r.scl_sync[1];
        sda_s      = c_r.sda_sync[1];
        prog       = ~c_r.mode_sync[1];                                    // [R18]
        prog_enter = prog & ~c_r.prog_d;
        scl_rise   = scl_s & ~c_r.scl_d;
        scl_fall   = ~scl_s & c_r.scl_d;
        start_det  = prog & scl_s & c_r.scl_d & c_r.sda_d & ~sda_s;        // [R4]
        stop_det   = prog & scl_s & c_r.scl_d & ~c_r.sda_d & sda_s;        // [R5]
        shifted    = {c_r.shift[6:0], sda_s};                              // [R6]
        rd_byte    = regs_r[c_r.ptr];
    end

    // ****************************************
    // Protocol engine
    // ****************************************
    always_comb begin
        c_nxt           = c_r;
        c_nxt.scl_sync  = {c_r.scl_sync[0], i_powerdown_or_serial_clock_pin};
        c_nxt.sda_sync  = {c_r.sda_sync[0], i_sda};
        c_nxt.mode_sync = {c_r.mode_sync[0], i_mode};
        c_nxt.scl_d     = scl_s;
        c_nxt.sda_d     = sda_s;
        c_nxt.prog_d    = prog;
        c_nxt.wr_pulse  = 1'b0;

        if (!prog) begin
            c_nxt.state     = I2CRF_IDLE;
            c_nxt.drive_low = 1'b0;                                        // [R21]
            c_nxt.ack_phase = 1'b0;
        end else if (start_det) begin                                      // [R4] [R12]
            c_nxt.state     = I2CRF_DADDR;
            c_nxt.bit_cnt   = 4'h0;
            c_nxt.ack_phase = 1'b0;
            c_nxt.drive_low = 1'b0;
        end else if (stop_det) begin                                       // [R5] [R12]
            c_nxt.state     = I2CRF_IDLE;                                  // [R3]
            c_nxt.ack_phase = 1'b0;
            c_nxt.drive_low = 1'b0;                                        // [R21]
        end else if (c_r.state != I2CRF_IDLE && c_r.state != I2CRF_SKIP) begin
            if (scl_rise) begin
                if (c_r.bit_cnt == BIT_CNT_ACK) begin
                    // Master acknowledge sample during read
                    if (c_r.state == I2CRF_RDATA) begin
                        c_nxt.rd_nack = sda_s;                             // [R8]
                    end
                end else begin
                    c_nxt.shift   = shifted;
                    c_nxt.bit_cnt = c_r.bit_cnt + 4'h1;
                end
            end else if (scl_fall) begin
                if (c_r.bit_cnt == BIT_CNT_ACK && !c_r.ack_phase) begin
                    // Ninth clock begins: decide acknowledge or next byte
                    c_nxt.ack_phase = 1'b1;
                    case (c_r.state)
                        I2CRF_DADDR: begin
                            if (c_r.shift[7:1] == DEV_ADDR) begin          // [R9] [R1] [R10]
                                c_nxt.drive_low = 1'b1;                    // [R7]
                            end else begin
                                c_nxt.state     = I2CRF_SKIP;
                                c_nxt.drive_low = 1'b0;
                            end
                        end
                        I2CRF_RADDR: begin
                            c_nxt.ptr       = c_r.shift[PTR_W-1:0];        // [R11] [R20]
                            c_nxt.drive_low = 1'b1;                        // [R7]
                        end
                        I2CRF_WDATA: begin
                            c_nxt.wr_pulse  = 1'b1;                        // [R14]
                            c_nxt.wr_addr   = c_r.ptr;
                            c_nxt.wr_data   = c_r.shift;
                            c_nxt.ptr       = c_r.ptr + 4'h1;              // [R13]
                            c_nxt.drive_low = 1'b1;                        // [R7]
                        end
                        default: begin
                            c_nxt.drive_low = 1'b0;                        // [R21]
                            c_nxt.ptr       = c_r.ptr + 4'h1;              // [R16] [R17]
                        end
                    endcase
                end else if (c_r.bit_cnt == BIT_CNT_ACK) begin
                    // End of ninth clock: release and advance
                    c_nxt.ack_phase = 1'b0;
                    c_nxt.bit_cnt   = 4'h0;
                    c_nxt.drive_low = 1'b0;                                // [R21]
                    case (c_r.state)
                        I2CRF_DADDR: begin
                            if (c_r.shift[0]) begin                        // [R15]
                                c_nxt.state     = I2CRF_RDATA;
                                c_nxt.shift     = rd_byte;
                                c_nxt.drive_low = ~rd_byte[7];
                            end else begin
                                c_nxt.state = I2CRF_RADDR;
                            end
                        end
                        I2CRF_RADDR: c_nxt.state = I2CRF_WDATA;            // [R11]
                        I2CRF_WDATA: c_nxt.state = I2CRF_WDATA;
                        default: begin
                            if (c_r.rd_nack) begin
                                c_nxt.state = I2CRF_SKIP;                  // [R8]
                            end else begin
                                c_nxt.shift     = rd_byte;                 // [R17]
                                c_nxt.drive_low = ~rd_byte[7];
                            end
                        end
                    endcase
                end else if (c_r.state == I2CRF_RDATA) begin
                    // Shift out next bit while clock low; shift moved it to the top
                    c_nxt.drive_low = ~c_r.shift[7];                       // [R6]
                end
            end
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            c_r.scl_sync  <= 2'b11;
            c_r.sda_sync  <= 2'b11;
            c_r.scl_d     <= 1'b1;
            c_r.sda_d     <= 1'b1;
            c_r.mode_sync <= 2'b11;
            c_r.prog_d    <= 1'b0;
            c_r.state     <= I2CRF_IDLE;
            c_r.bit_cnt   <= 4'h0;
            c_r.shift     <= 8'h00;
            c_r.ptr       <= '0;
            c_r.ack_phase <= 1'b0;
            c_r.drive_low <= 1'b0;
            c_r.rd_nack   <= 1'b0;
            c_r.wr_pulse  <= 1'b0;
            c_r.wr_addr   <= '0;
            c_r.wr_data   <= 8'h00;
        end else begin
            c_r <= c_nxt;
        end
    end

    generate
        for (genvar g = 0; g < NREGS; g++) begin : g_reg
            always_ff @(posedge i_clk_sys) begin
                if (!i_reset_n || prog_enter) begin
                    regs_r[g] <= REG_RESET_VAL;                            // [R19]
                end else if (c_r.wr_pulse && c_r.wr_addr == PTR_W'(g)) begin
                    regs_r[g] <= c_r.wr_data;                              // [R14]
                end
            end
            assign o_regs[g*8 +: 8] = regs_r[g];
        end
    endgenerate

    // ****************************************
    // Outputs
    // ****************************************
    assign o_sda         = 1'b0;
    assign o_sda_oe_n    = ~c_r.drive_low;                                 // [R21] [R2]
    assign o_reg_wr      = c_r.wr_pulse;
    assign o_reg_wr_addr = c_r.wr_addr;

endmodule : i2crf_slave

/* File: verif/i2crf_slave_checker.sv */
`timescale 1ns/1ps
module i2crf_slave_checker #(
    parameter int NREGS = i2crf_pkg::NUM_REGS
) (
    input wire logic                        i_clk_sys,
    input wire logic                        i_reset_n,
    input wire logic                        i_mode,
    input wire logic                        i_powerdown_or_serial_clock_pin,
    input wire logic                        i_sda,
    input wire logic                        o_sda,
    input wire logic                        o_sda_oe_n,
    input wire logic [NREGS*8-1:0]          o_regs,
    input wire logic                        o_reg_wr,
    input wire logic [i2crf_pkg::PTR_W-1:0] o_reg_wr_addr
);
    import i2crf_pkg::*;
    logic [PTR_W-1:0] last_r;
    logic [7:0]       gap_r;
    wire              scl_w = i_powerdown_or_serial_clock_pin;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    // ****
    // Spacing of register writes
    // ****
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            gap_r  <= 8'hff;
            last_r <= '0;
        end else if (o_reg_wr) begin
            gap_r  <= 8'h00;
            last_r <= o_reg_wr_addr;
        end else if (gap_r != 8'hff) begin
            gap_r  <= gap_r + 8'h01;
        end
    end
    property p_mode_idle; i_mode [*4] |-> o_sda_oe_n && !o_reg_wr; endproperty
    a_mode_idle: assert property (p_mode_idle) else $error("active outside program mode");
    property p_clear; $fell(i_mode) |-> ##[1:6] o_regs == '0; endproperty
    a_clear: assert property (p_clear) else $error("registers not cleared");
    property p_wr_ack; o_reg_wr |-> ##[0:6] !o_sda_oe_n; endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("write without acknowledge");
    property p_chg_low; $changed(o_sda_oe_n) && !i_mode |-> !$past(scl_w, 3); endproperty
    a_chg_low: assert property (p_chg_low) else $error("data changed while clock high");
    property p_hold; $fell(o_sda_oe_n) |-> (!o_sda_oe_n) [*7]; endproperty
    a_hold: assert property (p_hold) else $error("drive too short");
    property p_zero; !o_sda_oe_n |-> o_sda == 1'b0; endproperty
    a_zero: assert property (p_zero) else $error("data driven high");
    property p_inc; o_reg_wr && gap_r < 8'h64 |-> o_reg_wr_addr == last_r + 4'h1; endproperty
    a_inc: assert property (p_inc) else $error("pointer did not advance");
    property p_start; $fell(i_sda) && scl_w |-> ##1 o_sda_oe_n [*8]; endproperty
    a_start: assert property (p_start) else $error("line held after start");
    property p_stop; $rose(i_sda) && scl_w |-> ##1 (o_sda_oe_n && !o_reg_wr) [*8]; endproperty
    a_stop: assert property (p_stop) else $error("activity after stop");
    c_write: cover property (o_reg_wr);
    c_drive: cover property ($fell(o_sda_oe_n));
    c_mode: cover property ($fell(i_mode));
endmodule : i2crf_slave_checker
bind i2crf_slave i2crf_slave_checker #(.NREGS(NREGS)) u_i2crf_slave_checker (.i_clk_sys,
    .i_reset_n, .i_mode, .i_powerdown_or_serial_clock_pin, .i_sda, .o_sda, .o_sda_oe_n,
    .o_regs, .o_reg_wr, .o_reg_wr_addr);

/* File: verif/i2crf_master_model.sv */
`timescale 1ns/1ps
module i2crf_master_model (
    input  wire logic i_clk_sys,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic step(input logic c, input logic d);
        o_scl = c;
        o_sda = d;
        repeat (2) @(posedge i_clk_sys);
        #1;
    endtask : step
    task automatic start_c;
        step(1'b0, o_sda);
        step(1'b0, 1'b1);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask : start_c
    task automatic stop_c;
        step(1'b0, o_sda);
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask : stop_c
    task automatic bit_x(input logic b, output logic r);
        step(1'b0, o_sda);
        step(1'b0, b);
        step(1'b1, b);
        r = i_sda;
        step(1'b1, b);
    endtask : bit_x
    task automatic byte_x(input logic [7:0] d, input logic ak_in,
                          output logic [7:0] rd, output logic ak);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], rd[i]);
        end
        bit_x(ak_in, ak);
    endtask : byte_x
endmodule : i2crf_master_model

/* File: verif/i2crf_slave_tb.sv */
`timescale 1ns/1ps
module i2crf_slave_tb;
    import i2crf_pkg::*;
    logic                  i_clk_sys = 1'b0;
    logic                  i_reset_n = 1'b0;
    logic                  i_mode    = 1'b0;
    logic                  scl, m_sda, sda_w, o_sda, o_sda_oe_n, o_reg_wr;
    logic [NUM_REGS*8-1:0] o_regs;
    logic [PTR_W-1:0]      o_reg_wr_addr;
    logic [7:0]            exp_r [NUM_REGS];
    int                    mismatches = 0;
    int                    n_compared = 0;
    assign sda_w = m_sda & (o_sda_oe_n | o_sda);
    always #25 i_clk_sys = ~i_clk_sys;
    i2crf_slave u_i2crf_slave (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_mode(i_mode),
        .i_powerdown_or_serial_clock_pin(scl), .i_sda(sda_w), .o_sda(o_sda),
        .o_sda_oe_n(o_sda_oe_n), .o_regs(o_regs), .o_reg_wr(o_reg_wr),
        .o_reg_wr_addr(o_reg_wr_addr));
    i2crf_master_model u_m (.i_clk_sys(i_clk_sys), .i_sda(sda_w), .o_scl(scl), .o_sda(m_sda));
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic chk_ack(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t ack bit %b expected %b", $time, got, exp);
        end
    endtask : chk_ack
    task automatic chk_regs;
        for (int i = 0; i < NUM_REGS; i++) chk_byte(o_regs[i*8 +: 8], exp_r[i]);
    endtask : chk_regs
    task automatic addr_ph(input logic [6:0] dev, input logic rw, input logic exp);
        logic [7:0] rd;
        logic       ak;
        u_m.start_c;
        u_m.byte_x({dev, rw}, 1'b1, rd, ak);
        chk_ack(ak, exp);
    endtask : addr_ph
    task automatic set_ptr(input logic [7:0] ptr);
        logic [7:0] rd;
        logic       ak;
        addr_ph(DEV_ADDR, 1'b0, 1'b0);
        u_m.byte_x(ptr, 1'b1, rd, ak);
        chk_ack(ak, 1'b0);
    endtask : set_ptr
    task automatic t_burst_wrap;
        logic [7:0] rd;
        logic       ak;
        set_ptr(8'h1e);
        for (int k = 0; k < 3; k++) begin
            u_m.byte_x(8'ha1 + 8'(k), 1'b1, rd, ak);
            exp_r[4'(14 + k)] = 8'ha1 + 8'(k);
            chk_ack(ak, 1'b0);
            chk_byte(o_regs[(4'(14 + k))*8 +: 8], exp_r[4'(14 + k)]);
        end
        u_m.stop_c;
        chk_regs;
    endtask : t_burst_wrap
    task automatic rd_seq(input logic [7:0] ptr, input int n);
        logic [7:0] rd;
        logic       ak;
        set_ptr(ptr);
        addr_ph(DEV_ADDR, 1'b1, 1'b0);
        for (int k = 0; k < n; k++) begin
            u_m.byte_x(8'hff, k == n - 1, rd, ak);
            chk_byte(rd, exp_r[4'(ptr + k)]);
        end
        u_m.stop_c;
    endtask : rd_seq
    task automatic t_foreign;
        logic [6:0] devs [4] = '{7'h00, 7'h50, 7'h53, 7'h57};
        foreach (devs[i]) begin
            addr_ph(devs[i], 1'(i), 1'b1);
            u_m.stop_c;
        end
        chk_regs;
    endtask : t_foreign
    task automatic t_abort;
        logic r;
        set_ptr(8'h03);
        for (int i = 7; i > 3; i--) u_m.bit_x(i[0], r);
        set_ptr(8'h04);
        for (int i = 7; i > 2; i--) u_m.bit_x(i[0], r);
        u_m.stop_c;
        chk_regs;
    endtask : t_abort
    task automatic t_mode;
        @(posedge i_clk_sys);
        #1 i_mode = 1'b1;
        repeat (10) @(posedge i_clk_sys);
        addr_ph(DEV_ADDR, 1'b0, 1'b1);
        u_m.stop_c;
        @(posedge i_clk_sys);
        #1 i_mode = 1'b0;
        repeat (10) @(posedge i_clk_sys);
        foreach (exp_r[i]) exp_r[i] = REG_RESET_VAL;
        chk_regs;
    endtask : t_mode
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        #1_000_000;
        mismatches++;
        report_and_stop;
    end
    initial begin
        foreach (exp_r[i]) exp_r[i] = REG_RESET_VAL;
        repeat (6) @(posedge i_clk_sys);
        #1 i_reset_n = 1'b1;
        repeat (4) @(posedge i_clk_sys);
        chk_regs;
        t_burst_wrap;
        rd_seq(8'h0f, 1);
        rd_seq(8'h0e, 16);
        t_foreign;
        t_abort;
        t_mode;
        report_and_stop;
    end
endmodule : i2crf_slave_tb
